// *** hdl/pcmp_chan.v ***
`include "pcmp_regs.vh"
`default_nettype none
module pcmp_chan #(
  parameter COLL_BIT = `PCMP_BIT_COLL_A
) (
  input wire hclk,
  input wire hresetn,
  input wire ce,
  input wire signed [31:0] cur_pos,
  input wire signed [31:0] target,
  input wire [15:0] attr,
  output wire [4:0] evt,
  output wire above
);
  localparam ST_UNKNOWN = 3'b001;
  localparam ST_BELOW = 3'b010;
  localparam ST_ABOVE = 3'b100;
  reg [2:0] state;
  reg [2:0] next_state;
  wire is_above = cur_pos > target;
  wire is_below = cur_pos < target;
  // crossing detection on the remembered side
  wire up_hit = attr[`PCMP_BIT_UP] & (state == ST_BELOW) & is_above;
  wire dn_hit = attr[`PCMP_BIT_DOWN] & (state == ST_ABOVE) & is_below;
  wire hit = up_hit | dn_hit;
  // routing, unassigned attribute bits never looked at
  assign evt[0] = hit & attr[`PCMP_BIT_OUT_ONE];
  assign evt[1] = hit & attr[`PCMP_BIT_OUT_TWO];
  assign evt[2] = hit & attr[`PCMP_BIT_DIVA];
  assign evt[3] = hit & attr[`PCMP_BIT_DIVZ];
  assign evt[4] = hit & attr[COLL_BIT];
  assign above = (state == ST_ABOVE);
  always @* begin
    next_state = state;
    case (state)
      ST_UNKNOWN: begin
        if (is_above)
          next_state = ST_ABOVE;
        else if (is_below)
          next_state = ST_BELOW;
      end
      ST_BELOW: begin
        if (is_above)
          next_state = ST_ABOVE;
      end
      ST_ABOVE: begin
        if (is_below)
          next_state = ST_BELOW;
      end
      default: next_state = ST_UNKNOWN;
    endcase
  end
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      state <= ST_UNKNOWN;
    else if (ce)
      state <= next_state;
  end
endmodule // pcmp_chan
`default_nettype wire

// *** hdl/pcmp_regs.vh ***
`ifndef PCMP_REGS_VH
`define PCMP_REGS_VH
// register indices, byte address is four times the index
`define PCMP_IDX_TGT31 14'h195A
`define PCMP_IDX_ATTR31 14'h195C
`define PCMP_IDX_TGT32 14'h195D
`define PCMP_IDX_ATTR32 14'h195F
`define PCMP_IDX_TGT33 14'h1960
`define PCMP_IDX_ATTR33 14'h1962
`define PCMP_IDX_TGT34 14'h1963
`define PCMP_IDX_ATTR34 14'h1965
`define PCMP_IDX_STATUS 14'h1970
// attribute fields
`define PCMP_BIT_UP 0
`define PCMP_BIT_DOWN 1
`define PCMP_BIT_OUT_ONE 7
`define PCMP_BIT_OUT_TWO 8
`define PCMP_BIT_DIVA 12
`define PCMP_BIT_DIVZ 13
`define PCMP_BIT_COLL_A 15
`define PCMP_BIT_COLL_B 14
// reset values
`define PCMP_RST_TGT 32'h00000000
`define PCMP_RST_ATTR 16'h0000
`endif

// *** hdl/pcmp_top.v ***
// Local design decision: the AHB-Lite register port.
`include "pcmp_regs.vh"
`default_nettype none
module pcmp_top #(
  parameter NCH = 4
) (
  input wire hclk,
  input wire hresetn,
  input wire ce,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  input wire signed [31:0] cur_pos,
  output reg discrete_output_one,
  output reg discrete_output_two,
  output reg div_a_pulse,
  output reg div_z_pulse,
  output reg open_collector_index_pulse
);
  reg [31:0] tgt [0:NCH-1];
  reg [15:0] attr [0:NCH-1];
  reg dp_wr;
  reg [8:0] dp_sel;
  wire [4:0] evt [0:NCH-1];
  wire [NCH-1:0] above;
  integer j;
  integer k;
  integer m;

  // one-hot register selection codes
  localparam SEL_TGT31 = 9'h001;
  localparam SEL_TGT32 = 9'h002;
  localparam SEL_TGT33 = 9'h004;
  localparam SEL_TGT34 = 9'h008;
  localparam SEL_ATTR31 = 9'h010;
  localparam SEL_ATTR32 = 9'h020;
  localparam SEL_ATTR33 = 9'h040;
  localparam SEL_ATTR34 = 9'h080;
  localparam SEL_STATUS = 9'h100;

  // decode: bits 3:0 target, 7:4 attribute, 8 status
  function [8:0] dec;
    input [31:0] a;
    begin
      dec = 9'h000;
      if (a[1:0] == 2'h0 && a[31:16] == 16'h0000) begin
        case (a[15:2])
          `PCMP_IDX_TGT31: dec = SEL_TGT31;
          `PCMP_IDX_TGT32: dec = SEL_TGT32;
          `PCMP_IDX_TGT33: dec = SEL_TGT33;
          `PCMP_IDX_TGT34: dec = SEL_TGT34;
          `PCMP_IDX_ATTR31: dec = SEL_ATTR31;
          `PCMP_IDX_ATTR32: dec = SEL_ATTR32;
          `PCMP_IDX_ATTR33: dec = SEL_ATTR33;
          `PCMP_IDX_ATTR34: dec = SEL_ATTR34;
          `PCMP_IDX_STATUS: dec = SEL_STATUS;
          default: dec = 9'h000;
        endcase
      end
    end
  endfunction

  // address phase accepted
  wire accept = hsel & htrans[1] & hready & ce;
  wire [8:0] a_sel = dec(haddr);
  // read of the register being written returns new data
  wire fwd = dp_wr & (dp_sel == a_sel);

  // pick the addressed target and attribute
  reg [31:0] tgt_rd;
  reg [15:0] attr_rd;
  always @* begin
    tgt_rd = 32'h00000000;
    attr_rd = 16'h0000;
    for (j = 0; j < NCH; j = j + 1) begin
      if (a_sel[j])
        tgt_rd = tgt[j];
      if (a_sel[j + 4])
        attr_rd = attr[j];
    end
  end

  // channel sides as a status word
  wire [31:0] status_rd = {{(32 - NCH){1'b0}}, above};

  // read value seen by the address phase, with write forwarding
  wire sel_tgt = |a_sel[3:0];
  wire sel_attr = |a_sel[7:4];
  wire sel_status = a_sel[8];
  reg [31:0] rd_val;
  always @* begin
    rd_val = 32'h00000000;
    if (sel_tgt)
      rd_val = fwd ? hwdata : tgt_rd;
    else if (sel_attr)
      rd_val = {16'h0000, fwd ? hwdata[15:0] : attr_rd};
    else if (sel_status)
      rd_val = status_rd;
  end

  // zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // address phase captured for the data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr <= 1'b0;
      dp_sel <= 9'h000;
    end else if (ce && hready) begin
      dp_wr <= accept & hwrite;
      dp_sel <= accept ? a_sel : 9'h000;
    end
  end

  // read data loaded at the end of the address phase
  wire rd_take = accept & ~hwrite;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (rd_take)
      hrdata <= rd_val;
  end

  // data-phase write strobes
  wire [NCH-1:0] wr_tgt = dp_sel[NCH-1:0] & {NCH{dp_wr}};
  wire [NCH-1:0] wr_attr = dp_sel[NCH+3:4] & {NCH{dp_wr}};

  // register writes, live at once
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (k = 0; k < NCH; k = k + 1) begin
        tgt[k] <= `PCMP_RST_TGT;
        attr[k] <= `PCMP_RST_ATTR;
      end
    end else if (ce) begin
      for (k = 0; k < NCH; k = k + 1) begin
        if (wr_tgt[k])
          tgt[k] <= hwdata;
        if (wr_attr[k])
          attr[k] <= hwdata[15:0];
      end
    end
  end

  // one comparator per channel
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      pcmp_chan #(
        .COLL_BIT((g % 2 == 0) ? `PCMP_BIT_COLL_A : `PCMP_BIT_COLL_B)
      ) u_ch (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .cur_pos(cur_pos),
        .target(tgt[g]),
        .attr(attr[g]),
        .evt(evt[g]),
        .above(above[g])
      );
    end
  endgenerate

  // gather each destination across the channels
  reg [NCH-1:0] to_one;
  reg [NCH-1:0] to_two;
  reg [NCH-1:0] to_div_a;
  reg [NCH-1:0] to_div_z;
  reg [NCH-1:0] to_coll;
  always @* begin
    to_one = {NCH{1'b0}};
    to_two = {NCH{1'b0}};
    to_div_a = {NCH{1'b0}};
    to_div_z = {NCH{1'b0}};
    to_coll = {NCH{1'b0}};
    for (m = 0; m < NCH; m = m + 1) begin
      to_one[m] = evt[m][0];
      to_two[m] = evt[m][1];
      to_div_a[m] = evt[m][2];
      to_div_z[m] = evt[m][3];
      to_coll[m] = evt[m][4];
    end
  end

  // next output levels
  wire next_one = |to_one;
  wire next_two = |to_two;
  wire next_div_a = |to_div_a;
  wire next_div_z = |to_div_z;
  wire next_coll = |to_coll;

  // output pulses, every enabled destination driven
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      discrete_output_one <= 1'b0;
      discrete_output_two <= 1'b0;
      div_a_pulse <= 1'b0;
      div_z_pulse <= 1'b0;
      open_collector_index_pulse <= 1'b0;
    end else if (ce) begin
      discrete_output_one <= next_one;
      discrete_output_two <= next_two;
      div_a_pulse <= next_div_a;
      div_z_pulse <= next_div_z;
      open_collector_index_pulse <= next_coll;
    end
  end
endmodule // pcmp_top
`default_nettype wire

// *** verif/pcmp_partner.sv ***
`default_nettype none
module pcmp_partner (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [4:0] lines,
  output logic [19:0] counts
);
  timeunit 1ns / 1ns;
  // counts high cycles per line
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      counts <= 20'h00000;
    end else begin
      for (int i = 0; i < 5; i++) begin
        counts[i*4 +: 4] <= counts[i*4 +: 4] + 4'(lines[i]);
      end
    end
  end
endmodule // pcmp_partner
`default_nettype wire

// *** verif/pcmp_top_asserts.sv ***
`default_nettype none
module pcmp_top_asserts (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic signed [31:0] cur_pos,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic discrete_output_one,
  input wire logic discrete_output_two,
  input wire logic div_a_pulse,
  input wire logic div_z_pulse,
  input wire logic open_collector_index_pulse
);
  timeunit 1ns / 1ns;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // no motion and no write, so no event
  sequence q;
    (ce && $stable(cur_pos) && !(hsel && htrans[1] && hwrite)) [*5];
  endsequence
  chk_quiet_one: assert property (q |=> !discrete_output_one)
    else $error("stray pulse one");
  chk_quiet_two: assert property (q |=> !discrete_output_two)
    else $error("stray pulse two");
  chk_quiet_diva: assert property (q |=> !div_a_pulse)
    else $error("stray pulse a");
  chk_quiet_divz: assert property (q |=> !div_z_pulse)
    else $error("stray pulse z");
  chk_quiet_coll: assert property (q |=> !open_collector_index_pulse)
    else $error("stray pulse collector");
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  cover property (discrete_output_one);
  cover property (discrete_output_two && open_collector_index_pulse);
  cover property (div_a_pulse && div_z_pulse);
endmodule // pcmp_top_asserts
bind pcmp_top pcmp_top_asserts chk (
  .hclk(hclk),
  .hresetn(hresetn),
  .ce(ce),
  .hsel(hsel),
  .htrans(htrans),
  .hwrite(hwrite),
  .cur_pos(cur_pos),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .discrete_output_one(discrete_output_one),
  .discrete_output_two(discrete_output_two),
  .div_a_pulse(div_a_pulse),
  .div_z_pulse(div_z_pulse),
  .open_collector_index_pulse(open_collector_index_pulse)
);
`default_nettype wire

// *** verif/tb_top.sv ***
`include "pcmp_regs.vh"
`default_nettype none
module tb_top;
  timeunit 1ns / 1ns;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, ce = 1;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  logic signed [31:0] cur_pos = 32'h00000032;
  wire logic hreadyout, hresp;
  wire logic [31:0] hrdata;
  wire logic [4:0] o;
  wire logic [19:0] counts;
  int error_cnt = 0, num_checks = 0;
  always #25 hclk = ~hclk;
  pcmp_top uut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .cur_pos(cur_pos),
    .discrete_output_one(o[4]), .discrete_output_two(o[3]),
    .div_a_pulse(o[2]), .div_z_pulse(o[1]),
    .open_collector_index_pulse(o[0]));
  pcmp_partner far (.hclk(hclk), .hresetn(hresetn), .lines(o),
    .counts(counts));
  task wrap_up;
    if (error_cnt == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] seen, exp, input string nm);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        error_cnt++;
        wrap_up;
      end
      @(posedge hclk);
    end
  endtask
  task bus(input logic w, input logic [13:0] idx, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {16'h0000, idx, 2'h0};
    rdy;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    rd = hrdata;
  endtask
  task mv(input logic [31:0] p, input logic [4:0] e);
    cur_pos <= p;
    @(posedge hclk);
    #1;
    chk(32'(o), 32'(e), "outputs");
    @(posedge hclk);
  endtask
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, `PCMP_IDX_ATTR31, 32'h0);
    chk(rd, 32'h0, "attr31");
    bus(1'b1, `PCMP_IDX_TGT31, 32'h00000064);
    bus(1'b1, `PCMP_IDX_TGT32, 32'h00000000);
    bus(1'b1, `PCMP_IDX_TGT33, 32'hFFFFFFF6);
    bus(1'b1, `PCMP_IDX_ATTR31, 32'h00000081);
    bus(1'b1, `PCMP_IDX_ATTR32, 32'h00004102);
    bus(1'b1, `PCMP_IDX_ATTR33, 32'h0000B005);
    bus(1'b0, `PCMP_IDX_ATTR33, 32'h0);
    chk(rd, 32'h0000B005, "attr33");
    bus(1'b0, `PCMP_IDX_TGT33, 32'h0);
    chk(rd, 32'hFFFFFFF6, "tgt33");
    bus(1'b0, 14'h1000, 32'h0);
    chk(rd, 32'h0, "unmapped");
    mv(32'h00000096, 5'h10);
    mv(32'hFFFFFFCE, 5'h09);
    mv(32'h00000000, 5'h07);
    mv(32'h00000005, 5'h00);
    chk(32'(counts), 32'h00011112, "counts");
    bus(1'b0, `PCMP_IDX_STATUS, 32'h0);
    chk(rd, 32'h0000000E, "status");
    ce <= 1'b0;
    mv(32'h000000C8, 5'h00);
    ce <= 1'b1;
    mv(32'h000000C8, 5'h10);
    wrap_up;
  end
endmodule // tb_top
`default_nettype wire
